/* File: logic/olsm_fifo.v */
module olsm_fifo #(
    parameter WIDTH = 27,
    parameter DEPTH = 32,
    parameter ADDR_W = 5
) (
    input wire clock,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

// ----------------------------------------
// Storage and pointers
// ----------------------------------------
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [ADDR_W-1:0] wr_ptr;
reg [ADDR_W-1:0] rd_ptr;
reg [ADDR_W:0] count;
wire push;
wire pop;

assign in_ready = (count != DEPTH[ADDR_W:0]);
assign out_valid = (count != {(ADDR_W+1){1'b0}});
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;
assign out_data = mem[rd_ptr];

always @(posedge clock)
begin
    if (push)
    begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        wr_ptr <= {ADDR_W{1'b0}};
        rd_ptr <= {ADDR_W{1'b0}};
        count <= {(ADDR_W+1){1'b0}};
    end
    else
    begin
        if (push)
        begin
            wr_ptr <= (wr_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            rd_ptr <= (rd_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            count <= count + 1'b1;
        end
        else if (pop && !push)
        begin
            count <= count - 1'b1;
        end
    end
end

endmodule // olsm_fifo

/* File: logic/olsm_mux.v */
`include "olsm_regs.vh"

module olsm_mux #(
    parameter CLOCK_HZ = `OLSM_CLOCK_HZ,
    parameter SAMPLE_BITS = `OLSM_SAMPLE_BITS,
    parameter FIFO_DEPTH = `OLSM_FIFO_DEPTH
) (
    input wire clock,
    input wire rstn,
    input wire [1:0] rate_mode,
    input wire base_48k,
    output reg sample_tick,
    input wire in_valid,
    output wire in_ready,
    input wire [2:0] in_channel,
    input wire [SAMPLE_BITS-1:0] in_data,
    input wire link_clock,
    output reg link_data,
    output reg link_frame,
    output reg [1:0] frame_mode
);

// ----------------------------------------
// Sample rate divider
// ----------------------------------------
localparam [31:0] DIV_44_1 = CLOCK_HZ / `OLSM_RATE_44K_HZ;
localparam [31:0] DIV_48_1 = CLOCK_HZ / `OLSM_RATE_48K_HZ;
localparam [31:0] DIV_44_2 = CLOCK_HZ / (2 * `OLSM_RATE_44K_HZ);
localparam [31:0] DIV_48_2 = CLOCK_HZ / (2 * `OLSM_RATE_48K_HZ);
localparam [31:0] DIV_44_4 = CLOCK_HZ / (4 * `OLSM_RATE_44K_HZ);
localparam [31:0] DIV_48_4 = CLOCK_HZ / (4 * `OLSM_RATE_48K_HZ);
localparam DATA_W = SAMPLE_BITS * `OLSM_LINK_CHANNELS;
localparam FIFO_W = SAMPLE_BITS + 3;

reg [9:0] div_count;
reg [9:0] div_period;
reg [1:0] f_log;

always @*
begin
    case (rate_mode)
        `OLSM_MODE_DOUBLE:
        begin
            f_log = 2'h1;
        end
        `OLSM_MODE_QUAD:
        begin
            f_log = 2'h2;
        end
        default:
        begin
            f_log = 2'h0;
        end
    endcase
end

always @*
begin
    case (f_log)
        2'h1:
        begin
            div_period = base_48k ? DIV_48_2[9:0] : DIV_44_2[9:0];
        end
        2'h2:
        begin
            div_period = base_48k ? DIV_48_4[9:0] : DIV_44_4[9:0];
        end
        default:
        begin
            div_period = base_48k ? DIV_48_1[9:0] : DIV_44_1[9:0];
        end
    endcase
end

always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        div_count <= 10'h000;
        sample_tick <= 1'b0;
    end
    else if (div_count >= div_period - 10'h001)
    begin
        div_count <= 10'h000;
        sample_tick <= 1'b1;
    end
    else
    begin
        div_count <= div_count + 10'h001;
        sample_tick <= 1'b0;
    end
end

// ----------------------------------------
// Source buffer
// ----------------------------------------
wire fifo_valid;
wire fifo_ready;
wire [FIFO_W-1:0] fifo_word;

olsm_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .ADDR_W(5)
) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_channel, in_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_word)
);

// ----------------------------------------
// Link clock sampling
// ----------------------------------------
reg link_s1;
reg link_s2;
reg link_s3;
reg link_level;
wire link_rise;

always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        link_s1 <= 1'b0;
        link_s2 <= 1'b0;
        link_s3 <= 1'b0;
        link_level <= 1'b0;
    end
    else
    begin
        link_s1 <= link_clock;
        link_s2 <= link_s1;
        link_s3 <= link_s2;
        link_level <= (link_s2 == link_s3) ? link_s3 : link_level;
    end
end

assign link_rise = link_s2 && link_s3 && !link_level;

reg [7:0] bit_count;
wire frame_load;

assign frame_load = link_rise && (bit_count == `OLSM_FRAME_LAST);

// ----------------------------------------
// Slot mapping
// ----------------------------------------
wire [2:0] src_ch;
wire [SAMPLE_BITS-1:0] src_data;
wire [23:0] used_flat;
wire [2:0] src_used;
wire [2:0] factor;
wire keep;
wire [2:0] slot;
wire take;
wire [DATA_W-1:0] packed_data;
reg [1:0] cur_log;

always @*
begin
    case (frame_mode)
        `OLSM_MODE_DOUBLE:
        begin
            cur_log = 2'h1;
        end
        `OLSM_MODE_QUAD:
        begin
            cur_log = 2'h2;
        end
        default:
        begin
            cur_log = 2'h0;
        end
    endcase
end

assign src_ch = fifo_word[FIFO_W-1:SAMPLE_BITS];
assign src_data = fifo_word[SAMPLE_BITS-1:0];
assign src_used = used_flat[src_ch*3 +: 3];
assign factor = 3'h1 << cur_log;
assign keep = src_ch < (4'h8 >> cur_log);
assign slot = (src_ch << cur_log) | src_used;
assign fifo_ready = !frame_load && (!keep || (src_used < factor));
assign take = fifo_valid && fifo_ready && keep;

genvar i;
generate
    for (i = 0; i < `OLSM_LINK_CHANNELS; i = i + 1)
    begin : g_slot
        reg [SAMPLE_BITS-1:0] slot_q;
        reg [2:0] used_q;

        always @(posedge clock or negedge rstn)
        begin
            if (!rstn)
            begin
                slot_q <= {SAMPLE_BITS{1'b0}};
                used_q <= 3'h0;
            end
            else
            begin
                if (frame_load)
                begin
                    used_q <= 3'h0;
                end
                else if (take && (src_ch == i))
                begin
                    used_q <= used_q + 3'h1;
                end
                if (take && (slot == i))
                begin
                    slot_q <= src_data;
                end
            end
        end

        assign used_flat[i*3 +: 3] = used_q;
        assign packed_data[(`OLSM_LINK_CHANNELS-1-i)*SAMPLE_BITS +: SAMPLE_BITS] = slot_q;
    end
endgenerate

// ----------------------------------------
// Link serialiser
// ----------------------------------------
reg [DATA_W-1:0] shift_data;

always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        bit_count <= `OLSM_FRAME_LAST;
        shift_data <= {DATA_W{1'b0}};
        link_data <= 1'b0;
        link_frame <= 1'b0;
        frame_mode <= `OLSM_MODE_SINGLE;
    end
    else if (link_rise)
    begin
        bit_count <= bit_count + 8'h01;
        link_frame <= frame_load;
        if (frame_load)
        begin
            frame_mode <= (rate_mode == 2'h3) ? `OLSM_MODE_SINGLE : rate_mode;
            link_data <= packed_data[DATA_W-1];
            shift_data <= {packed_data[DATA_W-2:0], 1'b0};
        end
        else
        begin
            link_data <= (bit_count < `OLSM_DATA_LAST) ? shift_data[DATA_W-1] : 1'b0;
            shift_data <= {shift_data[DATA_W-2:0], 1'b0};
        end
    end
end

endmodule // olsm_mux

/* File: logic/olsm_regs.vh */
`ifndef OLSM_REGS_VH
`define OLSM_REGS_VH

// ----------------------------------------
// Clock and rates
// ----------------------------------------
`define OLSM_CLOCK_HZ 25000000
`define OLSM_RATE_44K_HZ 44100
`define OLSM_RATE_48K_HZ 48000

// ----------------------------------------
// Rate modes
// ----------------------------------------
`define OLSM_MODE_SINGLE 2'h0
`define OLSM_MODE_DOUBLE 2'h1
`define OLSM_MODE_QUAD 2'h2

// ----------------------------------------
// Link framing
// ----------------------------------------
`define OLSM_LINK_CHANNELS 8
`define OLSM_SAMPLE_BITS 24
`define OLSM_FRAME_BITS 256
`define OLSM_FRAME_LAST 8'hff
`define OLSM_DATA_LAST 8'hbf
`define OLSM_FIFO_DEPTH 32

`endif

/* File: verif/olsm_link_rx.sv */
module olsm_link_rx (
    output logic link_clock,
    input wire link_data,
    input wire link_frame,
    output logic [23:0] slot [0:7]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [255:0] sh;
    int n = 0;
    initial link_clock = 1'b0;
    always #160 link_clock = ~link_clock;
    always @(posedge link_clock)
    begin
        if (link_frame && n == 256)
            for (int k = 0; k < 8; k++)
                slot[k] = sh[255 - 24 * k -: 24];
        if (link_frame)
            n = 0;
        if (n < 256)
            sh[255 - n] = link_data;
        n++;
    end
endmodule // olsm_link_rx

/* File: verif/olsm_mux_asserts.sv */
module olsm_mux_asserts (
    input wire clock,
    input wire rstn,
    input wire sample_tick,
    input wire in_valid,
    input wire in_ready,
    input wire link_clock,
    input wire link_data,
    input wire link_frame,
    input wire [1:0] frame_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    reg s1, s2, s3, s4, rise_d;
    reg [7:0] bit_n;
    // -------------------
    // Link bit tracking
    // -------------------
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            {s1, s2, s3, s4, rise_d} <= 5'h00;
            bit_n <= 8'hff;
        end
        else
        begin
            {s1, s2, s3, s4, rise_d} <= {link_clock, s1, s2, s3, s3 & ~s4};
            if (rise_d)
                bit_n <= link_frame ? 8'h00 : bit_n + 8'h01;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_held; link_frame [*4]; endsequence
    property p_tick; sample_tick |=> !sample_tick; endproperty
    property p_bit; $changed(link_data) || $changed(link_frame) |-> rise_d; endproperty
    property p_len; rise_d |-> link_frame == (bit_n == 8'hff); endproperty
    property p_pad; bit_n >= 8'hc0 && !rise_d |-> !link_data; endproperty
    property p_hold; $rose(link_frame) |=> s_held; endproperty
    property p_mode; $changed(frame_mode) |-> $rose(link_frame); endproperty
    property p_fmode; link_frame |-> frame_mode != 2'h3; endproperty
    property p_ready; $fell(in_ready) |-> $past(in_valid); endproperty
    a_tick: assert property (p_tick) else $error("tick too long");
    a_bit: assert property (p_bit) else $error("bit off link edge");
    a_len: assert property (p_len) else $error("frame length");
    a_pad: assert property (p_pad) else $error("pad not zero");
    a_hold: assert property (p_hold) else $error("frame pulse short");
    a_mode: assert property (p_mode) else $error("mode mid frame");
    a_fmode: assert property (p_fmode) else $error("mode three kept");
    a_ready: assert property (p_ready) else $error("ready fell idle");
endmodule // olsm_mux_asserts

bind olsm_mux olsm_mux_asserts olsm_mux_asserts_i (.clock(clock), .rstn(rstn),
    .sample_tick(sample_tick), .in_valid(in_valid), .in_ready(in_ready),
    .link_clock(link_clock), .link_data(link_data), .link_frame(link_frame),
    .frame_mode(frame_mode));

/* File: verif/test_olsm_mux.sv */
module test_olsm_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] rate_mode = 2'h0;
    logic base_48k = 1'b0;
    logic in_valid = 1'b0;
    logic [2:0] in_channel = 3'h0;
    logic [23:0] in_data = 24'h00_0000;
    wire in_ready, link_clock, link_data, link_frame, sample_tick;
    wire [1:0] frame_mode;
    logic [23:0] slot [0:7];
    int err_count = 0;
    int samples_checked = 0;
    always #20 clock = ~clock;
    olsm_mux olsm_mux_i (.clock(clock), .rstn(rstn), .rate_mode(rate_mode), .base_48k(base_48k),
        .sample_tick(sample_tick), .in_valid(in_valid), .in_ready(in_ready),
        .in_channel(in_channel),
        .in_data(in_data), .link_clock(link_clock), .link_data(link_data),
        .link_frame(link_frame), .frame_mode(frame_mode));
    olsm_link_rx olsm_link_rx_i (.link_clock(link_clock), .link_data(link_data),
        .link_frame(link_frame), .slot(slot));
    // -------------------
    // Helpers
    // -------------------
    task finish_test;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [23:0] val(input logic [1:0] m, input logic b, input int c, input int n);
        return {m, b, 1'b1, c[3:0], n[3:0], 12'h3c9};
    endfunction
    task push(input int c, input logic [23:0] d);
        in_valid <= 1'b1;
        in_channel <= c[2:0];
        in_data <= d;
        @(negedge clock);
        for (int w = 0; in_ready !== 1'b1 && w < 99; w++)
            @(negedge clock);
        @(posedge clock);
    endtask
    task exercise(input logic [1:0] m, input logic b, input int f);
        time t0;
        rate_mode <= m;
        base_48k <= b;
        @(posedge link_frame);
        @(posedge clock);
        for (int c = 0; c < 8; c++)
            for (int n = 0; n < f; n++)
                push(c, val(m, b, c, n));
        in_valid <= 1'b0;
        @(posedge link_frame);
        t0 = $time;
        @(posedge link_frame);
        check("frame cycles", 24'h00_0800, 24'(($time - t0) / 40));
        #1000;
        for (int s = 0; s < 8; s++)
            check("slot", val(m, b, s / f, s % f), slot[s]);
        check("frame mode", {22'h00_0000, (m == 2'h3) ? 2'h0 : m}, {22'h00_0000, frame_mode});
        @(posedge clock);
    endtask
    task test_tick(input logic [1:0] m, input logic b, input int exp_cycles);
        int n;
        rate_mode <= m;
        base_48k <= b;
        repeat (600) @(posedge clock);
        @(negedge clock iff sample_tick === 1'b1);
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (sample_tick !== 1'b1 && n < 1000);
        check("tick period", exp_cycles[23:0], n[23:0]);
        @(posedge clock);
    endtask
    task test_fill;
        rate_mode <= 2'h0;
        in_valid <= 1'b1;
        in_channel <= 3'h0;
        repeat (40) @(posedge clock);
        @(negedge clock);
        check("full ready", 24'h00_0000, {23'h0, in_ready});
        @(posedge clock);
        in_valid <= 1'b0;
        rstn <= 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        check("reset ready", 24'h00_0001, {23'h0, in_ready});
        @(posedge clock);
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        exercise(2'h0, 1'b0, 1);
        exercise(2'h1, 1'b1, 2);
        exercise(2'h2, 1'b0, 4);
        exercise(2'h1, 1'b0, 2);
        test_tick(2'h1, 1'b0, 25_000_000 / 88_200);
        test_tick(2'h0, 1'b1, 25_000_000 / 48_000);
        test_tick(2'h2, 1'b1, 25_000_000 / 192_000);
        test_fill;
        exercise(2'h3, 1'b1, 1);
        finish_test;
    end
    initial
    begin
        #2_000_000;
        err_count++;
        $display("unexpected run time expected end seen timeout");
        finish_test;
    end
endmodule // test_olsm_mux
